// ===== logic/lhic_pkg.sv
/*
 Package for the limp-home and input control block: channel counts,
 select field width, reset values and device mode codes.
 Assumes nothing of its surroundings.
*/
package lhic_pkg;
   localparam int         LHIC_CHANNELS   = 8;
   localparam int         LHIC_DIRECT_INS = 4;
   localparam int         LHIC_LIMP_CHANS = 4;
   localparam int         LHIC_SEL_W      = 2;
   localparam logic [7:0] LHIC_OUT_RESET  = 8'h00;
   localparam logic [7:0] LHIC_ON_RESET   = 8'h00;
   localparam logic [7:0] LHIC_MODE_RESET = 8'h00;
   localparam logic [1:0] LHIC_SEL_RESET  = 2'h0;

   typedef enum logic [3:0] {
      LHIC_STANDBY = 4'h1,
      LHIC_IDLE    = 4'h2,
      LHIC_ACTIVE  = 4'h4,
      LHIC_LIMP    = 4'h8
   } lhic_state_type;
endpackage : lhic_pkg

// ===== logic/lhic_route.sv
/*
 Per-channel input matrix: picks the direct input named by each channel's
 select field, or the serial on bit when the channel is in serial control.
 Assumes the direct inputs are already synchronous to the clock.
*/
`timescale 1ns/100ps
module lhic_route
   import lhic_pkg::*;
(
   input  wire logic [LHIC_DIRECT_INS-1:0]           directIn,
   input  wire logic [LHIC_CHANNELS-1:0]             inputMode,
   input  wire logic [LHIC_CHANNELS-1:0]             serialOn,
   input  wire logic [LHIC_CHANNELS*LHIC_SEL_W-1:0]  inputSelect,
   output      logic [LHIC_CHANNELS-1:0]             chanCmd
);
   genvar ch;
   generate
      for (ch = 0; ch < LHIC_CHANNELS; ch++) begin : g_chan
         logic [LHIC_SEL_W-1:0] sel;
         assign sel = inputSelect[ch*LHIC_SEL_W +: LHIC_SEL_W];
         // High input means on, low means off
         assign chanCmd[ch] = inputMode[ch] ? directIn[sel] : serialOn[ch]; // R11 R12 R13
      end
   endgenerate
endmodule : lhic_route

// ===== logic/lhic_control.sv
/*
 Mode and input routing control of an eight-channel low-side switch.
 Assumes all inputs synchronous to clk; the serial frame decoder sits outside
 and presents written fields as write strobes with data.
*/
// Functional notes
// R1: Power-on reset clears all serial registers; idle mode, all channels off. Code: channels 1..4 follow the direct inputs if fail-safe is high.
// R2: Low reset pin forces defaults and minimum-current standby.
// R3: High fail-safe pin enters limp-home; registers held at reset values.
// R4: In limp-home, direct inputs 1..4 drive channels 1..4 directly.
// R5: In limp-home, channels 5..8 are held off.
// R6: In limp-home, serial traffic is ignored entirely.
// R7: Fail-safe request overrides a held low reset request.
// R8: Fail-safe request during standby wakes device into limp-home.
// R9: On fail-safe release, reset registers; standby if reset low, else idle.
// R10: First serial frame after limp-home exit carries transmission error flag.
// R11: Serially written select field picks which direct input drives a channel.
// R12: In input mode, direct input high means on, low means off.
// R13: In serial control, each channel follows its serial on bit.
// R14: Open direct input reads low, so its channels switch off.
// R15: Limp-home routing does not depend on the serial clock.
`timescale 1ns/100ps
module lhic_control
   import lhic_pkg::*;
(
   input  wire logic                                 clk,
   input  wire logic                                 reset,
   input  wire logic                                 resetRequest_n,
   input  wire logic                                 failsafeRequest,
   input  wire logic [LHIC_DIRECT_INS-1:0]           directInput,
   input  wire logic                                 frameStart,
   input  wire logic                                 frameEnd,
   input  wire logic                                 wrOnBits,
   input  wire logic [LHIC_CHANNELS-1:0]             wrOnData,
   input  wire logic                                 wrMode,
   input  wire logic [LHIC_CHANNELS-1:0]             wrModeData,
   input  wire logic                                 wrSelect,
   input  wire logic [LHIC_CHANNELS*LHIC_SEL_W-1:0]  wrSelectData,
   output      logic [LHIC_CHANNELS-1:0]             channelOutput,
   output      logic                                 transmissionErrorFlag,
   output      logic                                 limpHomeActive,
   output      logic                                 standbyActive,
   output      logic [LHIC_CHANNELS-1:0]             serialOnReadback,
   output      logic [LHIC_CHANNELS-1:0]             inputModeReadback
);
   lhic_state_type                          state_ff;
   lhic_state_type                          nxt_state;
   logic [LHIC_CHANNELS-1:0]                onBits_ff;
   logic [LHIC_CHANNELS-1:0]                modeBits_ff;
   logic [LHIC_CHANNELS*LHIC_SEL_W-1:0]     selBits_ff;
   logic                                    terPending_ff;
   logic                                    nxt_terPending;
   logic                                    nxt_terFlag;
   logic [LHIC_CHANNELS-1:0]                routedCmd;
   logic [LHIC_CHANNELS-1:0]                limpCmd;
   logic [LHIC_CHANNELS-1:0]                nxt_out;
   logic                                    inLimp;
   logic                                    limpExit;
   logic                                    pinReset;
   logic                                    forceOff;
   logic                                    clearRegs;
   logic                                    serialOk;
   logic                                    channelsUsed;
   logic                                    nxt_limpActive;
   logic                                    nxt_standbyActive;

   // Pin and state decode shared by the register, flag and output logic
   assign inLimp       = state_ff == LHIC_LIMP;
   assign limpExit     = inLimp && !failsafeRequest; // R9 R10
   assign pinReset     = !resetRequest_n; // R2
   assign forceOff     = reset || pinReset || inLimp; // R1 R2 R9
   assign channelsUsed = |onBits_ff || |modeBits_ff;

   // Registers are cleared while reset, the fail-safe request or the low reset pin stands
   assign clearRegs = reset || failsafeRequest || pinReset; // R1 R2 R3 R9
   // Strobes count only while no reset, no low reset pin and no fail-safe request stands
   assign serialOk  = !failsafeRequest && !pinReset && !reset; // R6

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         LHIC_STANDBY: begin
            if (failsafeRequest) begin
               nxt_state = LHIC_LIMP; // R7 R8
            end else if (resetRequest_n) begin
               nxt_state = LHIC_IDLE;
            end
         end
         LHIC_IDLE, LHIC_ACTIVE: begin
            if (failsafeRequest) begin
               nxt_state = LHIC_LIMP; // R3 R7
            end else if (pinReset) begin
               nxt_state = LHIC_STANDBY; // R2
            end else if (channelsUsed) begin
               nxt_state = LHIC_ACTIVE;
            end else begin
               nxt_state = LHIC_IDLE;
            end
         end
         LHIC_LIMP: begin
            if (!failsafeRequest) begin
               // Registers are already clear; only the landing state follows the pin
               nxt_state = resetRequest_n ? LHIC_IDLE : LHIC_STANDBY; // R9
            end
         end
         // An upset code falls back to standby, the lowest-current state
         default: begin
            nxt_state = LHIC_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= LHIC_IDLE; // R1
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign nxt_limpActive    = nxt_state == LHIC_LIMP;
   assign nxt_standbyActive = nxt_state == LHIC_STANDBY;

   // Serial on bits, one per channel
   always_ff @(posedge clk) begin
      if (clearRegs) begin
         onBits_ff <= LHIC_ON_RESET; // R1 R2 R3 R9
      end else if (serialOk && wrOnBits) begin // R6
         onBits_ff <= wrOnData; // R13
      end
   end

   // A set mode bit hands the channel over to its direct input
   always_ff @(posedge clk) begin
      if (clearRegs) begin
         modeBits_ff <= LHIC_MODE_RESET; // R1 R2 R3 R9
      end else if (serialOk && wrMode) begin // R6
         modeBits_ff <= wrModeData; // R12
      end
   end

   always_ff @(posedge clk) begin
      if (clearRegs) begin
         selBits_ff <= {LHIC_CHANNELS{LHIC_SEL_RESET}}; // R1 R2 R3 R9
      end else if (serialOk && wrSelect) begin // R6
         selBits_ff <= wrSelectData; // R11
      end
   end

   // Set on limp-home exit wins over the clear at a frame end
   always_comb begin
      nxt_terPending = terPending_ff;
      if (limpExit) begin
         nxt_terPending = 1'b1; // R10
      end else if (frameEnd && serialOk) begin
         nxt_terPending = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         terPending_ff <= 1'b0;
      end else begin
         terPending_ff <= nxt_terPending;
      end
   end

   // A frame that opens on the exit edge itself must already see the flag
   assign nxt_terFlag = terPending_ff || limpExit; // R10

   always_ff @(posedge clk) begin
      if (reset) begin
         transmissionErrorFlag <= 1'b0;
      end else if (frameStart && serialOk) begin
         transmissionErrorFlag <= nxt_terFlag; // R10
      end
   end

   lhic_route u_route (
      .directIn    (directInput), // R14 open pins are pulled low outside
      .inputMode   (modeBits_ff),
      .serialOn    (onBits_ff),
      .inputSelect (selBits_ff),
      .chanCmd     (routedCmd)
   );

   // Limp routing is taken straight from the pins, never through serial state
   genvar ch;
   generate
      for (ch = 0; ch < LHIC_CHANNELS; ch++) begin : g_limp
         if (ch < LHIC_LIMP_CHANS) begin : g_pin
            assign limpCmd[ch] = directInput[ch]; // R4 R15
         end else begin : g_off
            assign limpCmd[ch] = LHIC_OUT_RESET[ch]; // R5
         end
      end
   endgenerate

   always_comb begin
      nxt_out = routedCmd; // R11 R12 R13
      if (failsafeRequest) begin
         nxt_out = limpCmd; // R4 R5 R7
      end else if (forceOff) begin
         nxt_out = LHIC_OUT_RESET; // R1 R2 R9
      end
   end

   // Power-on reset must not blank the limp channels while the fail-safe pin is high
   always_ff @(posedge clk) begin
      if (reset && !failsafeRequest) begin
         channelOutput <= LHIC_OUT_RESET; // R1 R7
      end else begin
         channelOutput <= nxt_out;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         limpHomeActive <= 1'b0;
      end else begin
         limpHomeActive <= nxt_limpActive; // R3 R8
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         standbyActive <= 1'b0;
      end else begin
         standbyActive <= nxt_standbyActive; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         serialOnReadback <= LHIC_ON_RESET;
      end else begin
         serialOnReadback <= onBits_ff; // R13
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         inputModeReadback <= LHIC_MODE_RESET;
      end else begin
         inputModeReadback <= modeBits_ff; // R12
      end
   end
endmodule : lhic_control

// ===== bench/lhic_control_chk.sv
/* Port checker for lhic_control.
 Assumes the bind below reaches every lhic_control instance. */
`timescale 1ns/100ps
module lhic_control_chk
   import lhic_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       resetRequest_n,
   input wire logic       failsafeRequest,
   input wire logic [3:0] directInput,
   input wire logic       frameStart,
   input wire logic       frameEnd,
   input wire logic       wrOnBits,
   input wire logic [7:0] wrOnData,
   input wire logic [7:0] channelOutput,
   input wire logic       transmissionErrorFlag,
   input wire logic       limpHomeActive,
   input wire logic       standbyActive,
   input wire logic [7:0] serialOnReadback
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_exit;
      failsafeRequest ##1 !failsafeRequest;
   endsequence
   sequence s_quiet;
      !frameStart && !frameEnd && resetRequest_n && !failsafeRequest;
   endsequence
   sequence s_open;
      frameStart && resetRequest_n && !failsafeRequest;
   endsequence
   a_limp_off: assert property (failsafeRequest |=> channelOutput[7:4] == 4'h0)
      else $error("upper channels on in limp");
   a_limp_route: assert property (
      failsafeRequest |=> channelOutput[3:0] == $past(directInput))
      else $error("limp routing wrong");
   a_limp_enter: assert property (failsafeRequest |=> limpHomeActive && !standbyActive)
      else $error("limp not entered");
   a_standby_req: assert property (
      !resetRequest_n && !failsafeRequest |=> standbyActive && channelOutput == 8'h00)
      else $error("standby not entered");
   a_write_on: assert property (
      wrOnBits && resetRequest_n && !failsafeRequest ##1 !failsafeRequest && !wrOnBits
      |=> serialOnReadback == $past(wrOnData, 2))
      else $error("on bits not stored");
   a_limp_ignore: assert property (
      wrOnBits && failsafeRequest ##1 failsafeRequest |=> serialOnReadback == 8'h00)
      else $error("write taken in limp");
   a_exit_flag: assert property (
      s_exit ##1 s_quiet[*2] ##1 s_open |=> transmissionErrorFlag)
      else $error("error flag missing");
   a_exit_frame: assert property (
      failsafeRequest ##1 s_open |=> transmissionErrorFlag)
      else $error("error flag missing on exit edge");
   a_exit_state: assert property (
      s_exit |=> !limpHomeActive && channelOutput == 8'h00 && serialOnReadback == 8'h00
         && standbyActive == !$past(resetRequest_n))
      else $error("bad state after limp");
endmodule : lhic_control_chk
bind lhic_control lhic_control_chk chk_u (.clk, .reset, .resetRequest_n, .failsafeRequest,
   .directInput, .frameStart, .frameEnd, .wrOnBits, .wrOnData, .channelOutput,
   .transmissionErrorFlag, .limpHomeActive, .standbyActive, .serialOnReadback);

// ===== bench/lhic_mcu_model.sv
/* Controller-side model of the four direct input pins.
 Assumes the bench changes levels at the falling edge. */
`timescale 1ns/100ps
module lhic_mcu_model (
   input  wire logic [3:0] pinLevel,
   input  wire logic [3:0] pinOpen,
   output      logic [3:0] directInput
);
   // A floating pin is pulled to ground by the input sink
   assign directInput = pinLevel & ~pinOpen;
endmodule : lhic_mcu_model

// ===== bench/tb_top.sv
/* Self-checking bench for lhic_control.
 Assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
module tb_top;
   import lhic_pkg::*;
   logic        clk, reset, resetRequest_n, failsafeRequest, frameStart, frameEnd;
   logic        wrOnBits, wrMode, wrSelect, transmissionErrorFlag, limpHomeActive, standbyActive;
   logic [7:0]  wrOnData, wrModeData, channelOutput, serialOnReadback, inputModeReadback;
   logic [15:0] wrSelectData;
   logic [3:0]  pinLevel, pinOpen, directInput;
   int          errors, checks;
   lhic_control dut_u (.clk, .reset, .resetRequest_n, .failsafeRequest, .directInput,
      .frameStart, .frameEnd, .wrOnBits, .wrOnData, .wrMode, .wrModeData, .wrSelect,
      .wrSelectData, .channelOutput, .transmissionErrorFlag, .limpHomeActive,
      .standbyActive, .serialOnReadback, .inputModeReadback);
   lhic_mcu_model mdl_u (.pinLevel, .pinOpen, .directInput);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // k selects the strobe: 0 on bits, 1 mode, 2 select
   task automatic wr(input int k, input logic [15:0] d);
      wrOnData = d[7:0];
      wrModeData = d[7:0];
      wrSelectData = d;
      {wrSelect, wrMode, wrOnBits} = 3'h1 << k;
      tick(1);
      {wrSelect, wrMode, wrOnBits} = 3'h0;
      tick(1);
   endtask : wr
   task automatic test_done;
      if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   initial begin
      {reset, resetRequest_n, failsafeRequest, frameStart, frameEnd} = 5'h18;
      {wrOnBits, wrMode, wrSelect} = 3'h0;
      {wrOnData, wrModeData, wrSelectData} = 32'h0;
      {pinLevel, pinOpen} = 8'h00;
      errors = 0;
      checks = 0;
      tick(8);
      reset = 1'b0;
      tick(1);
      chk(channelOutput, 8'h00);
      chk(serialOnReadback, 8'h00);
      chk(inputModeReadback, 8'h00);
      wr(0, 16'h00a5);
      tick(1);
      chk(channelOutput, 8'ha5);
      pinLevel = 4'h8;
      wr(1, 16'h000f);
      wr(2, 16'h0093);
      tick(2);
      chk(channelOutput, 8'ha1);
      chk(inputModeReadback, 8'h0f);
      pinLevel = 4'h3;
      tick(2);
      chk(channelOutput, 8'ha6);
      pinOpen = 4'hf;
      tick(2);
      chk(channelOutput, 8'ha0);
      {pinLevel, pinOpen} = 8'h50;
      resetRequest_n = 1'b0;
      tick(2);
      chk({7'h00, standbyActive}, 8'h01);
      chk(serialOnReadback, 8'h00);
      chk(inputModeReadback, 8'h00);
      failsafeRequest = 1'b1;
      tick(2);
      chk(channelOutput, 8'h05);
      chk({7'h00, limpHomeActive}, 8'h01);
      wr(0, 16'h00ff);
      chk(serialOnReadback, 8'h00);
      failsafeRequest = 1'b0;
      tick(2);
      chk(channelOutput, 8'h00);
      chk({7'h00, standbyActive}, 8'h01);
      chk({7'h00, limpHomeActive}, 8'h00);
      {resetRequest_n, failsafeRequest} = 2'h3;
      tick(2);
      {failsafeRequest, frameStart} = 2'h1;
      tick(1);
      frameStart = 1'b0;
      chk({7'h00, transmissionErrorFlag}, 8'h01);
      tick(2);
      chk(channelOutput, 8'h00);
      chk({6'h00, standbyActive, limpHomeActive}, 8'h00);
      frameStart = 1'b1;
      tick(1);
      frameStart = 1'b0;
      chk({7'h00, transmissionErrorFlag}, 8'h01);
      frameEnd = 1'b1;
      tick(1);
      {frameEnd, frameStart} = 2'h1;
      tick(1);
      frameStart = 1'b0;
      chk({7'h00, transmissionErrorFlag}, 8'h00);
      test_done();
   end
endmodule : tb_top
